// file: dupc_pkg.sv
// constants shared by the converter controller and its trigger end
// Summary of operation
// RULE_01: enable gates analog only, registers stay accessible
// RULE_02: system reset disables converters, clears registers
// RULE_03: persist bit survives all resets except power-on
// RULE_04: one reference-select bit per converter pair
// RULE_05: one attenuation field per pair in config2
// RULE_06: per-converter output gain field in config1
// RULE_07: justify clear: right-justified twelve-bit word
// RULE_08: justify set: left-justified twelve-bit word
// RULE_09: low write blocks triggers, high write unblocks
// RULE_10: firmware writes low byte before high byte
// RULE_11: each converter selects its own trigger
// RULE_12: clock trigger updates cycle after high write
// RULE_13: other triggers: timer overflows, logic rising edges
// RULE_14: config1 holds four per-converter update blocks
// RULE_15: clearing several blocks updates outputs same edge
// RULE_16: converter 1 source: own, inverted, partner, inverted
// RULE_17: converter 3 source choices mirror converter 1
// RULE_18: alternating off: converter 1 uses selected source
// RULE_19: alternating on: trigger level picks data source
// RULE_20: alternating trigger high and low two cycles
// RULE_21: converter 3 alternating bit behaves the same
// RULE_22: second converter uses both words, first disabled
// RULE_23: attenuation codes 0,1,2; reset selects 2.4
// RULE_24: output holds last applied code between triggers
package dupc_pkg;
	localparam int NUM_CONV   = 4;
	localparam int CODE_W     = 12;
	localparam int NUM_TIMER  = 3;
	localparam int NUM_CLU    = 4;
	localparam int MIN_LEVEL_CYCLES = 2;

	localparam logic [7:0] OFS_GCF0      = 8'h00;
	localparam logic [7:0] OFS_GCF1      = 8'h04;
	localparam logic [7:0] OFS_GCF2      = 8'h08;
	localparam logic [7:0] OFS_STATUS    = 8'h0c;
	localparam logic [7:0] OFS_CONV_BASE = 8'h10;
	localparam logic [3:0] OFS_CF0       = 4'h0;
	localparam logic [3:0] OFS_CF1       = 4'h4;
	localparam logic [3:0] OFS_LOW       = 4'h8;
	localparam logic [3:0] OFS_HIGH      = 4'hc;

	localparam int G0_REF_A   = 0;
	localparam int G0_REF_B   = 1;
	localparam int G0_SRC1    = 2;
	localparam int G0_SRC3    = 4;
	localparam int G0_ALT1    = 6;
	localparam int G0_ALT3    = 7;
	localparam int G2_ATTEN_A = 0;
	localparam int G2_ATTEN_B = 4;
	localparam int CF0_EN     = 0;
	localparam int CF0_KEEP   = 1;
	localparam int CF0_LJ     = 2;
	localparam int CF0_TRIG   = 4;

	localparam logic [7:0] GCF0_RST  = 8'h00;
	localparam logic [3:0] GCF1_RST  = 4'h0;
	localparam logic [7:0] CF0_RST   = 8'h00;
	localparam logic [7:0] CF0_MASK  = 8'h77;
	localparam logic [7:0] BYTE_RST  = 8'h00;
	localparam logic [1:0] GAIN_RST  = 2'h1;

	localparam logic [1:0] ATTEN_2P0 = 2'h0;
	localparam logic [1:0] ATTEN_2P4 = 2'h1;
	localparam logic [1:0] ATTEN_3P0 = 2'h2;
	localparam logic [1:0] ATTEN_RST = ATTEN_2P4;

	localparam logic [2:0] TRIG_SYSTEM_CLOCK  = 3'h0;
	localparam logic [2:0] TRIG_TIMER_C = 3'h1;
	localparam logic [2:0] TRIG_TIMER_D = 3'h2;
	localparam logic [2:0] TRIG_TIMER_E = 3'h3;

	localparam logic [1:0] SRC_OWN         = 2'h0;
	localparam logic [1:0] SRC_OWN_INV     = 2'h1;
	localparam logic [1:0] SRC_PARTNER     = 2'h2;
	localparam logic [1:0] SRC_PARTNER_INV = 2'h3;
endpackage : dupc_pkg

// file: dupc_link_if.sv
// trigger link between the trigger sources and the converter controller
`timescale 1ns/10ps
interface dupc_link_if;
	logic [dupc_pkg::NUM_TIMER-1:0] timer_ovf;
	logic [dupc_pkg::NUM_CLU-1:0]   clu_out;

	modport trig_src (output timer_ovf, output clu_out);
	modport conv     (input timer_ovf, input clu_out);
endinterface : dupc_link_if

// file: dupc_trigger_end.sv
// timer overflow and logic-unit level source driving the trigger link
`timescale 1ns/10ps
module dupc_trigger_end #(
	parameter int MIN_CYCLES = dupc_pkg::MIN_LEVEL_CYCLES
) (
	input  wire logic                           clock,
	input  wire logic                           reset,
	input  wire logic                           clock_enable,
	input  wire logic [dupc_pkg::NUM_TIMER-1:0] timer_req,
	input  wire logic [dupc_pkg::NUM_CLU-1:0]   clu_req,
	dupc_link_if.trig_src                       link
);
	logic [dupc_pkg::NUM_TIMER-1:0] ovf_reg;
	logic [dupc_pkg::NUM_CLU-1:0]   level_reg;

	always_ff @(posedge clock)
	begin
		if (reset)
			ovf_reg <= '0;
		else if (clock_enable)
			ovf_reg <= timer_req;
	end

	genvar u;
	generate
		for (u = 0; u < dupc_pkg::NUM_CLU; u++)
		begin : g_clu
			logic [2:0] held_reg;
			// a requested change waits until the level has stood long enough
			always_ff @(posedge clock)
			begin
				if (reset)
				begin
					level_reg[u] <= 1'b0;
					held_reg     <= 3'(MIN_CYCLES);
				end
				else if (clock_enable)
				begin
					if (clu_req[u] != level_reg[u] && held_reg >= 3'(MIN_CYCLES))
					begin
						level_reg[u] <= clu_req[u]; // [RULE_20]
						held_reg     <= 3'h1;
					end
					else if (held_reg < 3'(MIN_CYCLES))
						held_reg <= held_reg + 3'h1;
				end
			end
		end
	endgenerate

	assign link.timer_ovf = ovf_reg;
	assign link.clu_out   = level_reg;
endmodule : dupc_trigger_end

// file: dupc_conv_ctrl.sv
// four-converter update, pairing and register control with apb slave
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module dupc_conv_ctrl #(
	parameter int ADDR_W = 8
) (
	input  wire logic                                           clock,
	input  wire logic                                           reset,
	input  wire logic                                           por_reset,
	input  wire logic                                           clock_enable,
	input  wire logic                                           psel,
	input  wire logic                                           penable,
	input  wire logic                                           pwrite,
	input  wire logic [ADDR_W-1:0]                              paddr,
	input  wire logic [31:0]                                    pwdata,
	output logic                                                pready,
	output logic [31:0]                                         prdata,
	output logic                                                pslverr,
	dupc_link_if.conv                                           link,
	output logic [dupc_pkg::NUM_CONV-1:0][dupc_pkg::CODE_W-1:0] conv_code,
	output logic [dupc_pkg::NUM_CONV-1:0]                       conv_enable,
	output logic [dupc_pkg::NUM_CONV-1:0][1:0]                  output_gain,
	output logic                                                pair_a_ref_select,
	output logic                                                pair_b_ref_select,
	output logic [1:0]                                          pair_a_ref_atten,
	output logic [1:0]                                          pair_b_ref_atten
);
	localparam int N = dupc_pkg::NUM_CONV;
	localparam int W = dupc_pkg::CODE_W;

	logic [7:0]   global_config0_reg;
	logic [3:0]   update_block_reg;
	logic [1:0]   atten_a_reg;
	logic [1:0]   atten_b_reg;
	logic         pready_reg;
	logic [31:0]  prdata_reg;
	logic         pslverr_reg;
	logic [31:0]  rdata_next;
	logic         err_next;
	logic [7:0]   conv_config0_reg [N];
	logic [1:0]   gain_reg [N];
	logic [7:0]   conv_data_low_reg [N];
	logic [7:0]   conv_data_high_reg [N];
	logic [W-1:0] code_reg [N];
	logic [N-1:0] inhibit_reg;
	logic [N-1:0] sys_pend_reg;
	logic [W-1:0] own_word [N];
	logic [dupc_pkg::NUM_CLU-1:0] clu_prev_reg;

	logic         access;
	logic         wr_hit;
	logic         conv_hit;
	logic [7:0]   conv_rel;
	logic [1:0]   conv_idx;
	logic [3:0]   conv_ofs;

	// one wait state so read data can come straight from a flop
	assign access   = psel & penable & clock_enable;
	assign wr_hit   = access & pready_reg & pwrite & ~pslverr_reg;
	assign conv_rel = 8'(paddr) - dupc_pkg::OFS_CONV_BASE;
	assign conv_hit = (8'(paddr) >= dupc_pkg::OFS_CONV_BASE) && (conv_rel[7:6] == 2'h0);
	assign conv_idx = conv_rel[5:4];
	assign conv_ofs = conv_rel[3:0];

	always_comb
	begin
		rdata_next = 32'h0000_0000;
		err_next   = 1'b0;
		if (paddr[1:0] != 2'h0 || ADDR_W > 8 && (paddr >> 8) != '0)
			err_next = 1'b1;
		else if (conv_hit)
		begin
			unique case (conv_ofs)
				dupc_pkg::OFS_CF0:  rdata_next[7:0] = conv_config0_reg[conv_idx]; // [RULE_01]
				dupc_pkg::OFS_CF1:  rdata_next[1:0] = gain_reg[conv_idx];
				dupc_pkg::OFS_LOW:  rdata_next[7:0] = conv_data_low_reg[conv_idx];
				dupc_pkg::OFS_HIGH: rdata_next[7:0] = conv_data_high_reg[conv_idx];
				default:            err_next = 1'b1;
			endcase
		end
		else
		begin
			unique case (8'(paddr))
				dupc_pkg::OFS_GCF0:   rdata_next[7:0] = global_config0_reg;
				dupc_pkg::OFS_GCF1:   rdata_next[3:0] = update_block_reg;
				dupc_pkg::OFS_GCF2:
				begin
					rdata_next[dupc_pkg::G2_ATTEN_A +: 2] = atten_a_reg;
					rdata_next[dupc_pkg::G2_ATTEN_B +: 2] = atten_b_reg;
				end
				// status: applied codes of all four converters cannot fit; show interlocks
				dupc_pkg::OFS_STATUS: rdata_next[7:0] = {sys_pend_reg, inhibit_reg};
				default:              err_next = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset | por_reset)
		begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end
		else if (clock_enable)
		begin
			pready_reg  <= access & ~pready_reg;
			prdata_reg  <= (access & ~pready_reg & ~pwrite) ? rdata_next : 32'h0000_0000;
			pslverr_reg <= access & ~pready_reg & err_next;
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset | por_reset)
		begin
			global_config0_reg <= dupc_pkg::GCF0_RST; // [RULE_02]
			update_block_reg   <= dupc_pkg::GCF1_RST;
			atten_a_reg        <= dupc_pkg::ATTEN_RST; // [RULE_23]
			atten_b_reg        <= dupc_pkg::ATTEN_RST;
		end
		else if (wr_hit && !conv_hit)
		begin
			if (8'(paddr) == dupc_pkg::OFS_GCF0)
				global_config0_reg <= pwdata[7:0]; // [RULE_04]
			if (8'(paddr) == dupc_pkg::OFS_GCF1)
				update_block_reg <= pwdata[3:0]; // [RULE_14]
			if (8'(paddr) == dupc_pkg::OFS_GCF2)
			begin
				atten_a_reg <= pwdata[dupc_pkg::G2_ATTEN_A +: 2]; // [RULE_05]
				atten_b_reg <= pwdata[dupc_pkg::G2_ATTEN_B +: 2];
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (reset | por_reset)
			clu_prev_reg <= '0;
		else if (clock_enable)
			clu_prev_reg <= link.clu_out;
	end

	genvar n;
	generate
		for (n = 0; n < N; n++)
		begin : g_conv
			logic         conv_rst;
			logic         wr_sel;
			logic [2:0]   trig_sel;
			logic         trig_lvl;
			logic         trig_prv;
			logic         alt_on;
			logic [1:0]   src_sel;
			logic         event_hit;
			logic [W-1:0] src_word;
			logic [W-1:0] code_next;

			// persistence only shields from the ordinary system reset
			assign conv_rst = por_reset | (reset & ~conv_config0_reg[n][dupc_pkg::CF0_KEEP]); // [RULE_02] [RULE_03]
			assign wr_sel   = wr_hit & conv_hit & (conv_idx == 2'(n));
			assign trig_sel = conv_config0_reg[n][dupc_pkg::CF0_TRIG +: 3];

			// [RULE_07] [RULE_08]
			assign own_word[n] = conv_config0_reg[n][dupc_pkg::CF0_LJ] ?
				{conv_data_high_reg[n], conv_data_low_reg[n][7:4]} :
				{conv_data_high_reg[n][3:0], conv_data_low_reg[n]};

			if (n % 2 == 1)
			begin : g_pair
				assign alt_on  = global_config0_reg[n == 1 ? dupc_pkg::G0_ALT1 : dupc_pkg::G0_ALT3]; // [RULE_21]
				assign src_sel = global_config0_reg[(n == 1 ? dupc_pkg::G0_SRC1 : dupc_pkg::G0_SRC3) +: 2];
			end
			else
			begin : g_single
				assign alt_on  = 1'b0;
				assign src_sel = dupc_pkg::SRC_OWN;
			end

			always_comb
			begin
				// [RULE_11] [RULE_13]
				unique case (trig_sel)
					dupc_pkg::TRIG_SYSTEM_CLOCK:
					begin
						trig_lvl = sys_pend_reg[n]; // [RULE_12]
						trig_prv = 1'b0;
					end
					dupc_pkg::TRIG_TIMER_C, dupc_pkg::TRIG_TIMER_D, dupc_pkg::TRIG_TIMER_E:
					begin
						trig_lvl = link.timer_ovf[trig_sel[1:0] - 2'h1];
						trig_prv = 1'b0;
					end
					default:
					begin
						trig_lvl = link.clu_out[trig_sel[1:0]];
						trig_prv = clu_prev_reg[trig_sel[1:0]];
					end
				endcase
				// [RULE_16] [RULE_17] [RULE_22]
				unique case (src_sel)
					dupc_pkg::SRC_OWN:         src_word = own_word[n];
					dupc_pkg::SRC_OWN_INV:     src_word = ~own_word[n];
					dupc_pkg::SRC_PARTNER:     src_word = own_word[n - (n % 2)];
					dupc_pkg::SRC_PARTNER_INV: src_word = ~own_word[n - (n % 2)];
				endcase
				// alternating mode follows both edges of a logic-unit trigger level
				code_next = (alt_on && !trig_lvl) ? own_word[n] : src_word; // [RULE_18] [RULE_19]
				event_hit = (alt_on ? (trig_lvl != trig_prv) : (trig_lvl & ~trig_prv))
					& ~inhibit_reg[n] & ~update_block_reg[n]; // [RULE_09] [RULE_14] [RULE_15]
			end

			always_ff @(posedge clock)
			begin
				if (conv_rst)
				begin
					conv_config0_reg[n]   <= dupc_pkg::CF0_RST;
					gain_reg[n]           <= dupc_pkg::GAIN_RST;
					conv_data_low_reg[n]  <= dupc_pkg::BYTE_RST;
					conv_data_high_reg[n] <= dupc_pkg::BYTE_RST;
				end
				else if (wr_sel)
				begin
					if (conv_ofs == dupc_pkg::OFS_CF0)
						conv_config0_reg[n] <= pwdata[7:0] & dupc_pkg::CF0_MASK;
					if (conv_ofs == dupc_pkg::OFS_CF1)
						gain_reg[n] <= pwdata[1:0]; // [RULE_06]
					if (conv_ofs == dupc_pkg::OFS_LOW)
						conv_data_low_reg[n] <= pwdata[7:0];
					if (conv_ofs == dupc_pkg::OFS_HIGH)
						conv_data_high_reg[n] <= pwdata[7:0];
				end
			end

			// interlock: low byte write arms, high byte write releases
			always_ff @(posedge clock)
			begin
				if (conv_rst)
				begin
					inhibit_reg[n]  <= 1'b0;
					sys_pend_reg[n] <= 1'b0;
				end
				else if (wr_sel && conv_ofs == dupc_pkg::OFS_LOW)
				begin
					inhibit_reg[n]  <= 1'b1; // [RULE_09] [RULE_10]
					sys_pend_reg[n] <= 1'b0;
				end
				else if (wr_sel && conv_ofs == dupc_pkg::OFS_HIGH)
				begin
					inhibit_reg[n]  <= 1'b0;
					// armed only under the clock trigger, a later switch to it must not replay
					sys_pend_reg[n] <= (trig_sel == dupc_pkg::TRIG_SYSTEM_CLOCK); // [RULE_12]
				end
				else if (clock_enable && event_hit && trig_sel == dupc_pkg::TRIG_SYSTEM_CLOCK)
					sys_pend_reg[n] <= 1'b0;
			end

			always_ff @(posedge clock)
			begin
				if (conv_rst)
					code_reg[n] <= '0;
				else if (clock_enable && event_hit)
					code_reg[n] <= code_next; // [RULE_24]
			end

			assign conv_code[n]   = code_reg[n];
			assign conv_enable[n] = conv_config0_reg[n][dupc_pkg::CF0_EN]; // [RULE_01]
			assign output_gain[n] = gain_reg[n];
		end
	endgenerate

	assign pready            = pready_reg;
	assign prdata            = prdata_reg;
	assign pslverr           = pslverr_reg;
	assign pair_a_ref_select = global_config0_reg[dupc_pkg::G0_REF_A]; // [RULE_04]
	assign pair_b_ref_select = global_config0_reg[dupc_pkg::G0_REF_B];
	assign pair_a_ref_atten  = atten_a_reg; // [RULE_05]
	assign pair_b_ref_atten  = atten_b_reg;
endmodule : dupc_conv_ctrl

// file: dupc_chk.sv
// assertions on the apb answer, the trigger link and the applied codes
`timescale 1ns/10ps
module dupc_chk (
	input wire logic             clock,
	input wire logic             reset,
	input wire logic             por_reset,
	input wire logic             psel,
	input wire logic             penable,
	input wire logic             pready,
	input wire logic             pslverr,
	input wire logic [31:0]      prdata,
	input wire logic [2:0]       timer_req,
	input wire logic [2:0]       timer_ovf,
	input wire logic [3:0]       clu_out,
	input wire logic [3:0][11:0] conv_code,
	input wire logic [1:0]       pair_a_ref_atten,
	input wire logic [1:0]       pair_b_ref_atten
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset || por_reset);
	property p_ready_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("access not answered after one wait");
	property p_ready_once;
		pready |-> psel && penable ##1 !pready;
	endproperty
	a_ready_once: assert property (p_ready_once) else $error("answer outside or beyond access");
	property p_rdata_idle;
		!pready |-> prdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
	property p_err_beat;
		pslverr |-> pready && prdata == 32'h0;
	endproperty
	a_err_beat: assert property (p_err_beat) else $error("error without answer or with data");
	property p_atten_rst;
		$fell(reset) |-> pair_a_ref_atten == dupc_pkg::ATTEN_RST && pair_b_ref_atten == dupc_pkg::ATTEN_RST;
	endproperty
	a_atten_rst: assert property (p_atten_rst) else $error("attenuation not at reset value");
	property p_ovf_follow;
		!$past(reset) |-> timer_ovf == $past(timer_req);
	endproperty
	a_ovf_follow: assert property (p_ovf_follow) else $error("overflow not one cycle after request");
	// a level change right after reset is allowed, the hold counters start full
	property p_clu_hold;
		!$past(reset) && !$past(reset, 2)
			|-> ((clu_out ^ $past(clu_out)) & ($past(clu_out) ^ $past(clu_out, 2))) == 4'h0;
	endproperty
	a_clu_hold: assert property (p_clu_hold) else $error("logic unit level held one cycle");
	property p_code_hold;
		!$past(pready) && !$past(pready, 2) && $past(timer_ovf) == 3'h0 && $past(clu_out) == $past(clu_out, 2)
			&& !$past(reset) && !$past(por_reset) |-> $stable(conv_code);
	endproperty
	a_code_hold: assert property (p_code_hold) else $error("code moved without a trigger");
endmodule : dupc_chk

// file: dac_update_and_pairing_control_test.sv
// self-checking bench for the converter controller and its trigger end
`timescale 1ns/10ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", nm, e, a); end end
module dac_update_and_pairing_control_test;
	logic             clock, reset, por_reset, clock_enable, psel, penable, pwrite, pready, pslverr, er;
	logic             pair_a_ref_select, pair_b_ref_select;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, prdata, rd;
	logic [2:0]       timer_req;
	logic [3:0]       clu_req, conv_enable;
	logic [3:0][11:0] conv_code;
	logic [3:0][1:0]  output_gain;
	logic [1:0]       pair_a_ref_atten, pair_b_ref_atten;
	logic [15:0]      seed = 16'h0019;
	logic [11:0]      w [4];
	logic [11:0]      ex [4];
	int               n_mismatch = 0;
	int               num_checks = 0;

	dupc_link_if link ();
	dupc_trigger_end u_dupc_trigger_end (.clock(clock), .reset(reset), .clock_enable(clock_enable),
		.timer_req(timer_req), .clu_req(clu_req), .link(link));
	dupc_conv_ctrl u_dupc_conv_ctrl (.clock(clock), .reset(reset), .por_reset(por_reset),
		.clock_enable(clock_enable), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .link(link),
		.conv_code(conv_code), .conv_enable(conv_enable), .output_gain(output_gain),
		.pair_a_ref_select(pair_a_ref_select), .pair_b_ref_select(pair_b_ref_select),
		.pair_a_ref_atten(pair_a_ref_atten), .pair_b_ref_atten(pair_b_ref_atten));
	dupc_chk u_dupc_chk (.clock(clock), .reset(reset), .por_reset(por_reset), .psel(psel), .penable(penable),
		.pready(pready), .pslverr(pslverr), .prdata(prdata), .timer_req(timer_req),
		.timer_ovf(link.timer_ovf), .clu_out(link.clu_out), .conv_code(conv_code),
		.pair_a_ref_atten(pair_a_ref_atten), .pair_b_ref_atten(pair_b_ref_atten));

	initial
	begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction : rnd

	function automatic logic [7:0] ca(input int n, input logic [3:0] o);
		return 8'h10 + 8'(n) * 8'h10 + {4'h0, o};
	endfunction : ca

	function automatic logic [11:0] srcf(input logic [1:0] s, input logic [11:0] own, input logic [11:0] par);
		return s[1] ? (s[0] ? ~par : par) : (s[0] ? ~own : own);
	endfunction : srcf

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick

	// holds the whole request until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clock);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (k >= 20)
		begin
			n_mismatch++;
			summarize();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wdat(input int n, input logic [11:0] v, input logic lj, input logic hi);
		if (hi)
			apb(1'b1, ca(n, dupc_pkg::OFS_HIGH), lj ? {24'h0, v[11:4]} : {28'h0, v[11:8]});
		else
			apb(1'b1, ca(n, dupc_pkg::OFS_LOW), lj ? {24'h0, v[3:0], 4'h0} : {24'h0, v[7:0]});
	endtask : wdat

	// low byte strictly before high byte
	task automatic setw(input int n, input logic [11:0] v, input logic lj);
		wdat(n, v, lj, 1'b0);
		wdat(n, v, lj, 1'b1);
		w[n] = v;
	endtask : setw

	// logic unit levels stand five cycles, above the two-cycle minimum
	task automatic fire(input int t);
		if (t < 4)
			timer_req <= 3'(1 << (t - 1));
		else
			clu_req <= 4'(1 << (t - 4));
		tick(1);
		timer_req <= 3'h0;
		tick(4);
		clu_req <= 4'h0;
		tick(4);
	endtask : fire

	initial
	begin
		int          n;
		logic [15:0] r;
		logic [11:0] v;
		logic [7:0]  c;
		logic [1:0]  s;
		reset = 1'b1;
		por_reset = 1'b1;
		clock_enable = 1'b1;
		{psel, penable, pwrite, paddr, pwdata, timer_req, clu_req} = '0;
		for (n = 0; n < 4; n++)
			ex[n] = 12'h0;
		tick(4);
		reset <= 1'b0;
		por_reset <= 1'b0;
		apb(1'b0, dupc_pkg::OFS_GCF2, 32'h0);
		`CHK("gcf2 reset", 32'h11, rd)
		apb(1'b0, ca(1, dupc_pkg::OFS_CF1), 32'h0);
		`CHK("gain reset", 32'h1, rd)
		for (n = 0; n < 2; n++)
		begin
			apb(1'b0, n ? 8'h50 : 8'h01, 32'h0);
			`CHK("refused", 33'h0_0000_0000 | 33'h1_0000_0000, {er, rd})
		end
		for (int i = 0; i < 12; i++)
		begin
			r = rnd();
			n = int'(r[1:0]);
			c = {5'h0, r[2], 1'b0, r[3]};
			apb(1'b1, ca(n, dupc_pkg::OFS_CF0), {24'h0, c});
			apb(1'b1, ca(n, dupc_pkg::OFS_CF1), 32'(r[5:4] % 2'h3));
			setw(n, 12'(rnd()), r[2]);
			tick(2);
			`CHK("word", w[n], conv_code[n])
			ex[n] = w[n];
			`CHK("gain", r[5:4] % 2'h3, output_gain[n])
			`CHK("enable", r[3], conv_enable[n])
			apb(1'b0, ca(n, dupc_pkg::OFS_CF0), 32'h0);
			`CHK("config0", {24'h0, c}, rd)
		end
		apb(1'b1, dupc_pkg::OFS_GCF1, 32'hf);
		for (n = 0; n < 4; n++)
		begin
			apb(1'b1, ca(n, dupc_pkg::OFS_CF0), 32'h1);
			setw(n, 12'(rnd()), 1'b0);
		end
		tick(3);
		for (n = 0; n < 4; n++)
			`CHK("blocked", ex[n], conv_code[n])
		apb(1'b1, dupc_pkg::OFS_GCF1, 32'h0);
		tick(1);
		for (n = 0; n < 4; n++)
			`CHK("before edge", ex[n], conv_code[n])
		tick(1);
		for (n = 0; n < 4; n++)
		begin
			`CHK("same edge", w[n], conv_code[n])
			ex[n] = w[n];
		end
		for (int i = 0; i < 4; i++)
		begin
			s = 2'(i);
			apb(1'b1, dupc_pkg::OFS_GCF0, {26'h0, s, s, s});
			tick(1);
			`CHK("ref a", s[0], pair_a_ref_select)
			`CHK("ref b", s[1], pair_b_ref_select)
			for (n = 0; n < 4; n++)
				setw(n, 12'(rnd()), 1'b0);
			tick(2);
			`CHK("conv1 source", srcf(s, w[1], w[0]), conv_code[1])
			`CHK("conv3 source", srcf(s, w[3], w[2]), conv_code[3])
		end
		for (int i = 0; i < 3; i++)
		begin
			apb(1'b1, dupc_pkg::OFS_GCF2, {26'h0, 2'(2 - i), 2'h0, 2'(i)});
			tick(1);
			`CHK("atten a", 2'(i), pair_a_ref_atten)
			`CHK("atten b", 2'(2 - i), pair_b_ref_atten)
		end
		// first converter of each pair left off while the second borrows its word
		apb(1'b1, ca(0, dupc_pkg::OFS_CF0), 32'h0);
		apb(1'b1, ca(2, dupc_pkg::OFS_CF0), 32'h0);
		apb(1'b1, dupc_pkg::OFS_GCF0, 32'he8);
		apb(1'b1, ca(1, dupc_pkg::OFS_CF0), 32'h41);
		apb(1'b1, ca(3, dupc_pkg::OFS_CF0), 32'h51);
		for (n = 0; n < 4; n++)
			setw(n, 12'(rnd()), 1'b0);
		clu_req <= 4'h3;
		tick(4);
		`CHK("alt1 high", w[0], conv_code[1])
		`CHK("alt3 high", w[2], conv_code[3])
		clu_req <= 4'h0;
		tick(4);
		`CHK("alt1 low", w[1], conv_code[1])
		`CHK("alt3 low", w[3], conv_code[3])
		ex[0] = w[0];
		apb(1'b1, dupc_pkg::OFS_GCF0, 32'h0);
		ex[2] = w[2];
		for (int t = 1; t < 8; t++)
		begin
			apb(1'b1, ca(2, dupc_pkg::OFS_CF0), {24'h0, 1'b0, 3'(t), 4'h1});
			v = 12'(rnd());
			wdat(2, v, 1'b0, 1'b0);
			apb(1'b0, dupc_pkg::OFS_STATUS, 32'h0);
			`CHK("status", 32'h4, rd)
			fire(t);
			`CHK("half word", ex[2], conv_code[2])
			wdat(2, v, 1'b0, 1'b1);
			tick(3);
			`CHK("held", ex[2], conv_code[2])
			fire(t);
			`CHK("trigger", v, conv_code[2])
			ex[2] = v;
		end
		// frozen clock: a trigger request must leave no trace
		v = 12'(rnd());
		setw(2, v, 1'b0);
		clock_enable <= 1'b0;
		fire(7);
		clock_enable <= 1'b1;
		tick(2);
		`CHK("frozen", ex[2], conv_code[2])
		fire(7);
		`CHK("thawed", v, conv_code[2])
		ex[2] = v;
		apb(1'b1, ca(0, dupc_pkg::OFS_CF0), 32'h3);
		apb(1'b1, ca(2, dupc_pkg::OFS_CF0), 32'h1);
		reset <= 1'b1;
		tick(1);
		reset <= 1'b0;
		tick(1);
		`CHK("kept code", ex[0], conv_code[0])
		`CHK("cleared code", 12'h0, conv_code[2])
		`CHK("enables", 4'h1, conv_enable)
		apb(1'b0, dupc_pkg::OFS_GCF2, 32'h0);
		`CHK("gcf2 again", 32'h11, rd)
		por_reset <= 1'b1;
		tick(1);
		por_reset <= 1'b0;
		tick(1);
		`CHK("power-on code", 12'h0, conv_code[0])
		`CHK("power-on enables", 4'h0, conv_enable)
		summarize();
	end
endmodule : dac_update_and_pairing_control_test
